// ==== verilog/qps_sequencer.sv ====
// Top of the quad phase fetch/execute sequencer
`timescale 1ns/100ps
module qps_sequencer #(
    parameter int INSTR_W = qps_pkg::INSTR_WIDTH,
    parameter int PC_W    = qps_pkg::PC_WIDTH
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [INSTR_W-1:0]      progData,
    output logic      [PC_W-1:0]         progAddr,
    output logic      [INSTR_W-1:0]      instrReg,
    output logic                         instrValid,
    output logic                         phaseOne,
    output logic                         phaseTwo,
    output logic                         phaseThree,
    output logic                         phaseFour,
    output logic                         cycleRateOutputPin,
    input  wire logic                    branchTaken,
    input  wire logic [PC_W-1:0]         branchTarget,
    output logic                         dataReadEn,
    output logic                         dataWriteEn,
    input  wire logic                    execWantsWrite,
    output logic                         branchFlush
);
    // Width check: the instruction word is fixed by the core, and the counter can be
    // no wider than its reset constant, which is sliced to fit
    if (INSTR_W != qps_pkg::INSTR_WIDTH
        || PC_W < 1 || PC_W > qps_pkg::PC_WIDTH) begin : g_bad_width
        $error("Unsupported sequencer widths");
    end

    qps_phase_if ph ();

    qps_phase_gen u_phase (
        .clk    (clk),
        .resetn (resetn),
        .ph     (ph.gen)
    );

    logic [PC_W-1:0]    pc_q, pc_d;
    logic [INSTR_W-1:0] fetch_q, fetch_d;
    logic               fetchValid_q, fetchValid_d;
    logic [INSTR_W-1:0] ir_q, ir_d;
    logic               irValid_q, irValid_d;
    logic               flush_q, flush_d;
    logic               branchPend_q, branchPend_d;
    logic               rd_q, rd_d;
    logic               wr_q, wr_d;
    logic               p1_q, p2_q, p3_q, p4_q, clkOut_q;
    logic               p1_d, p2_d, p3_d, p4_d, clkOut_d;
    logic [2:0]         sincePhaseOne_q, sincePhaseOne_d;

    // Phase one steps the counter only past a word that is already held and not
    // discarded; the counter names the word being fetched, so after reset or a jump
    // the loaded address is fetched first and is never skipped
    function automatic logic stepCounter(input logic held, input logic jumped);
        return held && !jumped;
    endfunction

    // Pipeline next-state: fetch and execute overlap each cycle
    always_comb begin
        pc_d         = pc_q;
        fetch_d      = fetch_q;
        fetchValid_d = fetchValid_q;
        ir_d         = ir_q;
        irValid_d    = irValid_q;
        flush_d      = flush_q;
        branchPend_d = branchPend_q;
        rd_d         = 1'b0;
        wr_d         = 1'b0;
        if (ph.phaseOne) begin
            // Prefetched word becomes the executing one unless flushed
            ir_d      = fetch_q;
            irValid_d = fetchValid_q && !branchPend_q;
            flush_d   = branchPend_q;
            branchPend_d = 1'b0;
            // First cycle after reset and the flushed cycle fetch the loaded address
            if (stepCounter(fetchValid_q, branchPend_q)) begin
                pc_d = pc_q + PC_W'(1);
            end
        end
        if (ph.phaseTwo && irValid_q) begin
            rd_d = 1'b1; // Registers together with the phase two output
        end
        if (ph.phaseFour) begin
            fetch_d      = progData;
            fetchValid_d = 1'b1;
            // Write strobe registers together with the phase four output
            if (irValid_q && execWantsWrite) begin
                wr_d = 1'b1;
            end
            // Branch redirects the counter; the word just fetched dies
            if (irValid_q && branchTaken) begin
                pc_d         = branchTarget;
                branchPend_d = 1'b1;
            end
        end
    end

    // Pipeline registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_q         <= qps_pkg::PC_RESET[PC_W-1:0];
            fetch_q      <= qps_pkg::IR_RESET;
            fetchValid_q <= 1'b0;
            ir_q         <= qps_pkg::IR_RESET;
            irValid_q    <= 1'b0;
            flush_q      <= 1'b0;
            branchPend_q <= 1'b0;
            rd_q         <= 1'b0;
            wr_q         <= 1'b0;
        end else begin
            pc_q         <= pc_d;
            fetch_q      <= fetch_d;
            fetchValid_q <= fetchValid_d;
            ir_q         <= ir_d;
            irValid_q    <= irValid_d;
            flush_q      <= flush_d;
            branchPend_q <= branchPend_d;
            rd_q         <= rd_d;
            wr_q         <= wr_d;
        end
    end

    // Phase outputs copy the internal strobes; the extra flop costs one clock of lag
    always_comb begin
        p1_d     = ph.phaseOne;
        p2_d     = ph.phaseTwo;
        p3_d     = ph.phaseThree;
        p4_d     = ph.phaseFour;
        clkOut_d = ph.cycleRate;
    end

    // Phase outputs are re-registered so every port leaves a flip-flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_q     <= 1'b0;
            p2_q     <= 1'b0;
            p3_q     <= 1'b0;
            p4_q     <= 1'b0;
            clkOut_q <= 1'b0;
        end else begin
            p1_q     <= p1_d;
            p2_q     <= p2_d;
            p3_q     <= p3_d;
            p4_q     <= p4_d;
            clkOut_q <= clkOut_d;
        end
    end

    // Helper count of clocks since the last phase one, so the cycle length is checked
    // apart from the phase decoder; it saturates so a stuck generator cannot wrap
    always_comb begin
        if (ph.phaseOne) begin
            sincePhaseOne_d = 3'h1;
        end else if (sincePhaseOne_q != 3'h7) begin
            sincePhaseOne_d = sincePhaseOne_q + 3'h1;
        end else begin
            sincePhaseOne_d = sincePhaseOne_q;
        end
    end

    // Helper count register; zero after reset marks the first cycle as unchecked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sincePhaseOne_q <= 3'h0;
        end else begin
            sincePhaseOne_q <= sincePhaseOne_d;
        end
    end

    // Output mapping; registered phases lag the internal phase by one clock
    assign progAddr           = pc_q;
    assign instrReg           = ir_q;
    assign instrValid         = irValid_q;
    assign phaseOne           = p1_q;
    assign phaseTwo           = p2_q;
    assign phaseThree         = p3_q;
    assign phaseFour          = p4_q;
    assign cycleRateOutputPin = clkOut_q;
    assign dataReadEn         = rd_q;
    assign dataWriteEn        = wr_q;
    assign branchFlush        = flush_q;

    // Counter, fetch and register timing against the internal phase
    AST_PC_STEP: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseOne && stepCounter(fetchValid_q, branchPend_q))
            |=> pc_q == $past(pc_q) + PC_W'(1))
        else $error("Counter did not step in phase one");
    AST_PC_PARK: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseOne && !stepCounter(fetchValid_q, branchPend_q)) |=> $stable(pc_q))
        else $error("Counter stepped before its loaded word was fetched");
    AST_PC_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseTwo || ph.phaseThree) |=> $stable(pc_q))
        else $error("Counter moved outside phase one or four");
    AST_TARGET_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseFour && irValid_q && branchTaken) |=> pc_q == $past(branchTarget))
        else $error("Branch target not loaded into the counter");
    AST_FETCH_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
        ph.phaseFour |=> fetch_q == $past(progData))
        else $error("Program word not captured in phase four");
    AST_IR_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        ph.phaseOne |=> ir_q == $past(fetch_q))
        else $error("Instruction register not loaded in phase one");
    AST_CYCLE_LENGTH: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseOne && sincePhaseOne_q != 3'h0)
            |-> sincePhaseOne_q == 3'(qps_pkg::PHASES_PER_CYCLE))
        else $error("Instruction cycle is not four clocks");
    // Data strobes against the registered phase outputs; flush against the data strobes and the internal phase four
    AST_READ_PHASE: assert property (@(posedge clk) disable iff (!resetn)
        rd_q |-> p2_q && irValid_q)
        else $error("Operand read outside phase two");
    AST_WRITE_PHASE: assert property (@(posedge clk) disable iff (!resetn)
        wr_q |-> p4_q && irValid_q && !flush_q)
        else $error("Write outside phase four or while flushed");
    AST_FLUSH_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        flush_q |-> !rd_q && !wr_q && !irValid_q)
        else $error("Discarded instruction touched data memory");
    AST_FLUSH_ONE: assert property (@(posedge clk) disable iff (!resetn)
        (ph.phaseFour && irValid_q && branchTaken) |=> ##1 (flush_q && !irValid_q) [*4]
        ##1 !flush_q)
        else $error("Flush not exactly one cycle");
    AST_CLKOUT_RATE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(clkOut_q) |=> clkOut_q ##1 !clkOut_q [*2] ##1 clkOut_q)
        else $error("Clock output not quarter rate");
    AST_FIRST_FETCH: assert property (@(posedge clk)
        $rose(resetn) |-> !irValid_q ##1 !irValid_q [*4])
        else $error("Valid execute right after reset");

    COV_BRANCH: cover property (@(posedge clk) disable iff (!resetn) $rose(flush_q));
    COV_WRITE: cover property (@(posedge clk) disable iff (!resetn) wr_q);
    COV_READ: cover property (@(posedge clk) disable iff (!resetn) rd_q);
    COV_BACK2BACK: cover property (@(posedge clk) disable iff (!resetn)
        $fell(flush_q) ##4 irValid_q);
endmodule

// ==== shared/qps_pkg.sv ====
// Package of constants and types for the quad phase fetch/execute sequencer
package qps_pkg;
    localparam int INSTR_WIDTH = 14;
    localparam int PC_WIDTH    = 13;
    localparam int DATA_ADDR_WIDTH = 7;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [13:0] IR_RESET = 14'h0000;

    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } qps_phase_t;
endpackage

// ==== shared/qps_phase_if.sv ====
// Interface carrying phase strobes between the phase generator and the sequencer
`timescale 1ns/100ps
interface qps_phase_if;
    logic phaseOne;
    logic phaseTwo;
    logic phaseThree;
    logic phaseFour;
    logic cycleRate;

    modport gen  (output phaseOne, output phaseTwo, output phaseThree, output phaseFour,
                  output cycleRate);
    modport user (input phaseOne, input phaseTwo, input phaseThree, input phaseFour,
                  input cycleRate);
endinterface

// ==== verilog/qps_phase_gen.sv ====
// Four-phase generator dividing the oscillator clock by four
`timescale 1ns/100ps
module qps_phase_gen (
    input  wire logic   clk,
    input  wire logic   resetn,
    qps_phase_if.gen    ph
);
    qps_pkg::qps_phase_t phase_q, phase_d;

    // Next phase rotates one step per clock
    always_comb begin
        unique case (phase_q)
            qps_pkg::PH_ONE:   phase_d = qps_pkg::PH_TWO;
            qps_pkg::PH_TWO:   phase_d = qps_pkg::PH_THREE;
            qps_pkg::PH_THREE: phase_d = qps_pkg::PH_FOUR;
            qps_pkg::PH_FOUR:  phase_d = qps_pkg::PH_ONE;
        endcase
    end

    // Reset parks the phase at one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= qps_pkg::PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Decoded strobes are mutually exclusive by construction
    assign ph.phaseOne   = (phase_q == qps_pkg::PH_ONE);
    assign ph.phaseTwo   = (phase_q == qps_pkg::PH_TWO);
    assign ph.phaseThree = (phase_q == qps_pkg::PH_THREE);
    assign ph.phaseFour  = (phase_q == qps_pkg::PH_FOUR);
    // High in phases one and two: one quarter of the oscillator rate
    assign ph.cycleRate  = (phase_q == qps_pkg::PH_ONE) || (phase_q == qps_pkg::PH_TWO);

    AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!resetn)
        ph.phaseOne |=> ph.phaseTwo ##1 ph.phaseThree ##1 ph.phaseFour ##1 ph.phaseOne)
        else $error("Phase order broken");
    AST_ONE_HOT: assert property (@(posedge clk) disable iff (!resetn)
        $onehot({ph.phaseOne, ph.phaseTwo, ph.phaseThree, ph.phaseFour}))
        else $error("Phases overlap");
endmodule

// ==== verification/qps_prog_mem.sv ====
// Program memory model answering the sequencer's fetch address
`timescale 1ns/100ps
module qps_prog_mem #(
    parameter int SLOW = 1
) (
    input  wire logic        clk,
    input  wire logic [12:0] progAddr,
    output logic      [13:0] progData
);
    logic [12:0] lastAddr_q;
    int          age_q;
    // Age of the current address, so slow answers can be modelled
    always_ff @(posedge clk) begin
        lastAddr_q <= progAddr;
        age_q      <= (progAddr == lastAddr_q) ? age_q + 1 : 0;
    end
    // Unsettled reads show inverted junk, so an early capture is caught
    assign progData = (age_q >= SLOW && progAddr == lastAddr_q) ? {1'b1, progAddr}
                                                             : ~{1'b1, progAddr};
endmodule

// ==== verification/quad_phase_fetch_execute_sequencer_bench.sv ====
// Self-checking bench for the quad phase fetch/execute sequencer
`timescale 1ns/100ps
module quad_phase_fetch_execute_sequencer_bench;
    logic        clk, resetn, branchTaken, execWantsWrite, instrValid;
    logic        phaseOne, phaseTwo, phaseThree, phaseFour, cycleRateOutputPin;
    logic        dataReadEn, dataWriteEn, branchFlush;
    logic [13:0] progData, instrReg;
    logic [12:0] progAddr, branchTarget, prevAddr;
    logic [3:0]  ph;
    int          fails, samples_checked;

    qps_sequencer u_qps_sequencer (.clk, .resetn, .progData, .progAddr, .instrReg,
        .instrValid, .phaseOne, .phaseTwo, .phaseThree, .phaseFour, .cycleRateOutputPin,
        .branchTaken, .branchTarget, .dataReadEn, .dataWriteEn, .execWantsWrite,
        .branchFlush);
    qps_prog_mem #(.SLOW(1)) u_qps_prog_mem (.clk, .progAddr, .progData);

    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out;
        $display("checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Sample just after the edge, once its updates have landed
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // One instruction cycle; write wish is held for the cycle, branch request is raised only from phase four
    task automatic cyc(input logic w, input logic br);
        int n;
        logic v;
        @(posedge clk) begin
            execWantsWrite <= w;
            branchTaken    <= 1'b0;
        end
        n = 0;
        do begin
            tick();
            n++;
        end while (phaseTwo !== 1'b1 && n < 8);
        if (phaseTwo !== 1'b1) begin
            fails++;
            close_out();
        end
        v = instrValid;
        check(dataReadEn === v, "operand read strobe");
        if (v === 1'b1) check(instrReg === {1'b1, progAddr - 13'h0001}, "ir word");
        @(posedge clk) branchTaken <= br;
        #1;
        tick();
        check(phaseFour === 1'b1 && dataWriteEn === (v & w), "write strobe");
    endtask

    task automatic t_phases;
        tick();
        ph = {phaseOne, phaseTwo, phaseThree, phaseFour};
        repeat (16) begin
            tick();
            check({phaseOne, phaseTwo, phaseThree, phaseFour} === {ph[0], ph[3:1]},
                  "phase order");
            check(cycleRateOutputPin === (phaseOne | phaseTwo), "rate pin");
            ph = {phaseOne, phaseTwo, phaseThree, phaseFour};
        end
        $display("test phases done");
    endtask

    // Straight-line code: one word per cycle, counter steps by one
    task automatic t_stream;
        cyc(1'b0, 1'b0);
        prevAddr = progAddr;
        for (int i = 0; i < 6; i++) begin
            cyc(i[0], 1'b0);
            check(instrValid === 1'b1 && progAddr === prevAddr + 13'h0001, "stream");
            prevAddr = progAddr;
        end
        $display("test stream done");
    endtask

    // Taken branch, then a request in the flushed cycle that must be ignored
    task automatic t_branch;
        @(posedge clk) branchTarget <= 13'h0ABC;
        cyc(1'b1, 1'b1);
        cyc(1'b1, 1'b1);
        check(branchFlush === 1'b1 && instrValid === 1'b0, "flush cycle");
        cyc(1'b0, 1'b0);
        check(branchFlush === 1'b0 && instrReg === 14'h2ABC, "target runs");
        $display("test branch done");
    endtask

    // Reset mid-run: all quiet, then a fetch-only first cycle
    task automatic t_reset;
        @(posedge clk) resetn <= 1'b0;
        tick();
        check({progAddr, instrReg, instrValid, phaseOne, phaseTwo, phaseThree, phaseFour,
               cycleRateOutputPin, dataReadEn, dataWriteEn, branchFlush} === '0, "reset");
        repeat (3) tick();
        @(posedge clk) resetn <= 1'b1;
        cyc(1'b1, 1'b0);
        check(instrValid === 1'b0, "fetch only first");
        cyc(1'b0, 1'b0);
        check(instrValid === 1'b1 && instrReg === 14'h2000, "first word");
        $display("test reset done");
    endtask

    // Main sequence
    initial begin
        resetn         = 1'b0;
        branchTaken    = 1'b0;
        execWantsWrite = 1'b0;
        branchTarget   = 13'h0000;
        fails          = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        @(posedge clk) resetn <= 1'b1;
        t_phases();
        t_stream();
        t_branch();
        t_reset();
        close_out();
    end
endmodule
